/* File: prer_pkg.sv */
`default_nettype none
package prer_pkg;
  // Configuration offsets (byte addresses)
  localparam logic [11:0] OFF_ROOT_PORT_CONTROL   = 12'h080;
  localparam logic [11:0] OFF_ROOT_PORT_STATUS    = 12'h084;
  localparam logic [11:0] OFF_POSTED_CREDITS      = 12'h0C4;
  localparam logic [11:0] OFF_NONPOSTED_CREDITS   = 12'h0C8;
  localparam logic [11:0] OFF_EXT_CAP_HEADER      = 12'h100;
  localparam logic [11:0] OFF_UNCOR_STATUS        = 12'h104;
  localparam logic [11:0] OFF_UNCOR_MASK          = 12'h108;
  localparam logic [11:0] OFF_HEADER_LOG0         = 12'h11C;
  // Root control bit positions
  localparam int          BIT_SERR_COR            = 0;
  localparam int          BIT_SERR_NONFATAL       = 1;
  localparam int          BIT_SERR_FATAL          = 2;
  localparam int          BIT_PME_INT_EN          = 3;
  localparam logic [3:0]  ROOT_CONTROL_RESET      = 4'h0;
  // Root status bit positions
  localparam int          BIT_PME_STATUS          = 16;
  localparam int          BIT_PME_PENDING         = 17;
  // Uncorrectable error status bit positions
  localparam int          BIT_UNSUPPORTED         = 20;
  localparam int          BIT_MALFORMED           = 18;
  localparam int          BIT_RX_OVERFLOW         = 17;
  localparam int          BIT_UNEXP_CPL           = 16;
  localparam int          BIT_CPL_ABORT           = 15;
  localparam int          BIT_CPL_TIMEOUT         = 14;
  localparam int          BIT_FC_PROTOCOL         = 13;
  localparam int          BIT_POISONED            = 12;
  localparam int          BIT_DL_PROTOCOL         = 4;
  localparam logic [31:0] UNCOR_IMPL_MASK         = 32'h0017_F010;
  localparam logic [31:0] UNCOR_HDRLOG_MASK       = 32'h0017_9000;
  localparam logic [31:0] UNCOR_STATUS_RESET      = 32'h0000_0000;
  localparam logic [31:0] UNCOR_MASK_RESET        = 32'h0000_0000;
  // Fixed read-only values
  localparam logic [31:0] POSTED_CREDITS_VALUE    = 32'h000C_0030;
  localparam logic [31:0] NONPOSTED_CREDITS_VALUE = 32'h0008_0001;
  localparam logic [31:0] EXT_CAP_HEADER_VALUE    = 32'h0001_0001;
  // Error message kinds
  localparam logic [1:0]  MSG_COR                 = 2'h0;
  localparam logic [1:0]  MSG_NONFATAL            = 2'h1;
  localparam logic [1:0]  MSG_FATAL               = 2'h2;
  // Completion timer
  localparam int          CLK_MHZ                 = 125;
  localparam int          TICK_CYCLES             = CLK_MHZ;
  localparam int          CPL_TIMEOUT_MIN_US      = 50;
  localparam int          CPL_TIMEOUT_MAX_MS      = 16;
  localparam int          CPL_TIMEOUT_US          = CPL_TIMEOUT_MAX_MS * 1000;
  // Link widths
  localparam int          SEQ_W                   = 12;
  localparam int          TAG_W                   = 5;
  localparam logic [11:0] ACKED_SEQ_RESET         = 12'hFFF;
endpackage
`default_nettype wire

/* File: prer_root_port_regs.sv */
// Summary of operation
// - PME interrupt raised on PME message while PME interrupt enable is set.
// - Enabling PME interrupt with status already set raises it at once.
// - Fatal messages give system error when control bit 2 and command enable set.
// - Nonfatal messages give system error when control bit 1 and command enable set.
// - Correctable messages give system error only when control bit 0 is set.
// - PME status bit 16 set on PME; software clears it writing one.
// - Requester ID of the PME flagged by status bit 16 held read-only in bits 15:0.
// - PME pending bit 17 marks a waiting PME, cleared when none remain.
// - Posted credit register reads header 0Ch and data 030h, zeros elsewhere.
// - Non-posted credit register reads header 08h and data 001h, zeros elsewhere.
// - Capability header reads ID 0001h, version 1h, next pointer 000h.
// - Uncorrectable status bits set on error, survive warm reset, write one clears.
// - Header log loads on an unsupported, malformed, overflow, unexpected completion, abort or poisoned error only while no uncorrectable status bit is set.
// - Length, byte-enable or illegal field problems flag malformed packet.
// - Overflow of posted, non-posted or completion queue flags receiver overflow.
// - Completion matching no outstanding request flags unexpected completion.
// - Legal request breaking the programming model flags completer abort.
// - Request timer expires between 50 us and 16 ms, flagging timeout.
// - Finite update to credit first advertised infinite flags flow control error.
// - Received poisoned payload flags poisoned packet status.
// - ACK or NAK naming an invalid sequence number flags link protocol error.
// - End-to-end CRC, training error and reserved bits read zero.
// - Masked errors are still logged but send no error message.
`timescale 1ns/10ps
`default_nettype none
module prer_root_port_regs #(
  parameter int NUM_OUTSTANDING = 4,
  parameter int CPL_TIMEOUT_US  = prer_pkg::CPL_TIMEOUT_US
) (
  input  wire logic                       I_MCLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_PWR_RST,
  input  wire logic [11:0]                I_CFG_ADDR,
  input  wire logic                       I_CFG_WR,
  input  wire logic                       I_CFG_RD,
  input  wire logic [3:0]                 I_CFG_BE,
  input  wire logic [31:0]                I_CFG_WDATA,
  output logic      [31:0]                O_CFG_RDATA,
  output logic                            O_CFG_RVALID,
  input  wire logic                       I_CMD_SERR_EN,
  input  wire logic                       I_ERR_MSG_VALID,
  input  wire logic [1:0]                 I_ERR_MSG_KIND,
  output logic                            O_SYSTEM_ERROR,
  input  wire logic                       I_PME_MSG_VALID,
  input  wire logic [15:0]                I_PME_REQ_ID,
  output logic                            O_PME_INT,
  input  wire logic [127:0]               I_RX_HDR,
  input  wire logic                       I_RX_UNSUPPORTED,
  input  wire logic                       I_RX_LEN_ERR,
  input  wire logic                       I_RX_BE_ERR,
  input  wire logic                       I_RX_FIELD_ERR,
  input  wire logic                       I_RX_POISONED,
  input  wire logic                       I_RX_ABORT_REQ,
  input  wire logic [2:0]                 I_Q_PUSH,
  input  wire logic [2:0]                 I_Q_FULL,
  input  wire logic                       I_REQ_ISSUE,
  input  wire logic [prer_pkg::TAG_W-1:0] I_REQ_TAG,
  output logic                            O_REQ_READY,
  input  wire logic                       I_CPL_VALID,
  input  wire logic [prer_pkg::TAG_W-1:0] I_CPL_TAG,
  input  wire logic                       I_FC_INIT_VALID,
  input  wire logic                       I_FC_UPD_VALID,
  input  wire logic [1:0]                 I_FC_TYPE,
  input  wire logic [7:0]                 I_FC_HDR,
  input  wire logic [11:0]                I_FC_DATA,
  input  wire logic                       I_TLP_SENT,
  input  wire logic                       I_ACK_VALID,
  input  wire logic [prer_pkg::SEQ_W-1:0] I_ACK_SEQ,
  output logic                            O_UNCOR_MSG
);
  import prer_pkg::*;

  localparam int TIME_W = $clog2(CPL_TIMEOUT_US + 1);
  localparam logic [TIME_W-1:0] TIME_LIMIT = TIME_W'(CPL_TIMEOUT_US);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [3:0]                       ctrl;
    logic                             pme_status;
    logic                             pme_pending;
    logic [15:0]                      pme_id;
    logic [15:0]                      pme_pend_id;
    logic [31:0]                      unc_sts;
    logic [31:0]                      unc_mask;
    logic [127:0]                     hdr_log;
    logic [7:0]                       tick_cnt;
    logic [NUM_OUTSTANDING-1:0]       ent_valid;
    logic [NUM_OUTSTANDING-1:0][TAG_W-1:0]  ent_tag;
    logic [NUM_OUTSTANDING-1:0][TIME_W-1:0] ent_time;
    logic [5:0]                       fc_inf;
    logic [SEQ_W-1:0]                 next_seq;
    logic [SEQ_W-1:0]                 acked_seq;
    logic [31:0]                      rdata;
    logic                             rvalid;
    logic                             serr;
    logic                             pme_int;
    logic                             unc_msg;
    logic                             req_ready;
  } prer_state_t;

  prer_state_t st;
  prer_state_t next_st;

  logic [31:0]            wmask;
  logic [31:0]            err_ev;
  logic [31:0]            sts_clr;
  logic                   sel_ctrl;
  logic                   sel_rpsts;
  logic                   sel_usts;
  logic                   sel_umask;
  logic                   pme_clr;
  logic                   tick;
  logic                   cpl_hit;
  logic                   alloc_done;
  logic                   timeout_ev;
  logic                   serr_ok;
  logic [SEQ_W-1:0]       seq_dist;
  logic [SEQ_W-1:0]       seq_out;
  logic [31:0]            rd_word;
  logic [11:0]            hdr_off;

  always_comb begin
    next_st    = st;
    wmask      = {{8{I_CFG_BE[3]}}, {8{I_CFG_BE[2]}}, {8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};
    err_ev     = 32'h0000_0000;
    sel_ctrl   = I_CFG_WR && (I_CFG_ADDR[11:2] == OFF_ROOT_PORT_CONTROL[11:2]);
    sel_rpsts  = I_CFG_WR && (I_CFG_ADDR[11:2] == OFF_ROOT_PORT_STATUS[11:2]);
    sel_usts   = I_CFG_WR && (I_CFG_ADDR[11:2] == OFF_UNCOR_STATUS[11:2]);
    sel_umask  = I_CFG_WR && (I_CFG_ADDR[11:2] == OFF_UNCOR_MASK[11:2]);
    pme_clr    = sel_rpsts && I_CFG_BE[2] && I_CFG_WDATA[BIT_PME_STATUS];
    sts_clr    = sel_usts ? (I_CFG_WDATA & wmask) : 32'h0000_0000;
    tick       = (st.tick_cnt == TICK_LAST);
    cpl_hit    = 1'b0;
    alloc_done = 1'b0;
    timeout_ev = 1'b0;
    serr_ok    = 1'b0;
    seq_dist   = I_ACK_SEQ - st.acked_seq;
    seq_out    = st.next_seq - st.acked_seq - 12'h001;
    rd_word    = 32'h0000_0000;
    hdr_off    = I_CFG_ADDR - OFF_HEADER_LOG0;

    // Control register
    if (sel_ctrl && I_CFG_BE[0]) begin
      next_st.ctrl = I_CFG_WDATA[3:0];
    end

    // PME status, pending and requester ID
    if (pme_clr && st.pme_pending) begin
      next_st.pme_status  = 1'b1;
      next_st.pme_id      = st.pme_pend_id;
      next_st.pme_pending = I_PME_MSG_VALID;
      if (I_PME_MSG_VALID) begin
        next_st.pme_pend_id = I_PME_REQ_ID;
      end
    end else if (pme_clr) begin
      next_st.pme_status = I_PME_MSG_VALID;
      if (I_PME_MSG_VALID) begin
        next_st.pme_id = I_PME_REQ_ID;
      end
    end else if (I_PME_MSG_VALID) begin
      if (st.pme_status) begin
        next_st.pme_pending = 1'b1;
        next_st.pme_pend_id = I_PME_REQ_ID;
      end else begin
        next_st.pme_status = 1'b1;
        next_st.pme_id     = I_PME_REQ_ID;
      end
    end
    // Level request follows enable and status of the coming cycle
    next_st.pme_int = next_st.ctrl[BIT_PME_INT_EN] && next_st.pme_status;

    // System error from received error messages
    case (I_ERR_MSG_KIND)
      MSG_FATAL: begin
        serr_ok = st.ctrl[BIT_SERR_FATAL] && I_CMD_SERR_EN;
      end
      MSG_NONFATAL: begin
        serr_ok = st.ctrl[BIT_SERR_NONFATAL] && I_CMD_SERR_EN;
      end
      MSG_COR: begin
        serr_ok = st.ctrl[BIT_SERR_COR];
      end
      default: begin
        serr_ok = 1'b0;
      end
    endcase
    next_st.serr = I_ERR_MSG_VALID && serr_ok;

    // Microsecond tick for completion timers
    next_st.tick_cnt = tick ? 8'h00 : st.tick_cnt + 8'h01;

    // Outstanding requests: match, age, expire, allocate
    for (int i = 0; i < NUM_OUTSTANDING; i++) begin
      if (st.ent_valid[i]) begin
        if (I_CPL_VALID && (st.ent_tag[i] == I_CPL_TAG) && !cpl_hit) begin
          cpl_hit              = 1'b1;
          next_st.ent_valid[i] = 1'b0;
        end else if (st.ent_time[i] == TIME_LIMIT) begin
          timeout_ev           = 1'b1;
          next_st.ent_valid[i] = 1'b0;
        end else if (tick) begin
          next_st.ent_time[i] = st.ent_time[i] + TIME_W'(1);
        end
      end else if (I_REQ_ISSUE && st.req_ready && !alloc_done) begin
        alloc_done           = 1'b1;
        next_st.ent_valid[i] = 1'b1;
        next_st.ent_tag[i]   = I_REQ_TAG;
        next_st.ent_time[i]  = '0;
      end
    end
    next_st.req_ready = ~&next_st.ent_valid;

    // Flow control credit tracking: two flags per type, header and data
    if (I_FC_INIT_VALID && (I_FC_TYPE != 2'h3)) begin
      next_st.fc_inf[{I_FC_TYPE, 1'b0}] = (I_FC_HDR == 8'h00);
      next_st.fc_inf[{I_FC_TYPE, 1'b1}] = (I_FC_DATA == 12'h000);
    end
    if (I_FC_UPD_VALID && (I_FC_TYPE != 2'h3)) begin
      if ((st.fc_inf[{I_FC_TYPE, 1'b0}] && (I_FC_HDR != 8'h00)) ||
          (st.fc_inf[{I_FC_TYPE, 1'b1}] && (I_FC_DATA != 12'h000))) begin
        err_ev[BIT_FC_PROTOCOL] = 1'b1;
      end
    end

    // Data link sequence tracking
    if (I_TLP_SENT) begin
      next_st.next_seq = st.next_seq + 12'h001;
    end
    if (I_ACK_VALID) begin
      if (seq_dist <= seq_out) begin
        next_st.acked_seq = I_ACK_SEQ;
      end else begin
        err_ev[BIT_DL_PROTOCOL] = 1'b1;
      end
    end

    // Error events
    err_ev[BIT_UNSUPPORTED] = I_RX_UNSUPPORTED;
    err_ev[BIT_MALFORMED]   = I_RX_LEN_ERR || I_RX_BE_ERR || I_RX_FIELD_ERR;
    err_ev[BIT_RX_OVERFLOW] = |(I_Q_PUSH & I_Q_FULL);
    err_ev[BIT_UNEXP_CPL]   = I_CPL_VALID && !cpl_hit;
    err_ev[BIT_CPL_ABORT]   = I_RX_ABORT_REQ;
    err_ev[BIT_CPL_TIMEOUT] = timeout_ev;
    err_ev[BIT_POISONED]    = I_RX_POISONED;

    // Sticky status: a new event wins over a clear in the same cycle
    next_st.unc_sts = ((st.unc_sts & ~sts_clr) | err_ev) & UNCOR_IMPL_MASK;
    if (((st.unc_sts & UNCOR_IMPL_MASK) == 32'h0000_0000) &&
        ((err_ev & UNCOR_HDRLOG_MASK) != 32'h0000_0000)) begin
      next_st.hdr_log = I_RX_HDR;
    end
    if (sel_umask) begin
      next_st.unc_mask = ((st.unc_mask & ~wmask) | (I_CFG_WDATA & wmask)) & UNCOR_IMPL_MASK;
    end
    next_st.unc_msg = |(err_ev & ~st.unc_mask & UNCOR_IMPL_MASK);

    // Configuration read
    case (I_CFG_ADDR[11:2])
      OFF_ROOT_PORT_CONTROL[11:2]: begin
        rd_word = {28'h000_0000, st.ctrl};
      end
      OFF_ROOT_PORT_STATUS[11:2]: begin
        rd_word = {14'h0000, st.pme_pending, st.pme_status, st.pme_id};
      end
      OFF_POSTED_CREDITS[11:2]: begin
        rd_word = POSTED_CREDITS_VALUE;
      end
      OFF_NONPOSTED_CREDITS[11:2]: begin
        rd_word = NONPOSTED_CREDITS_VALUE;
      end
      OFF_EXT_CAP_HEADER[11:2]: begin
        rd_word = EXT_CAP_HEADER_VALUE;
      end
      OFF_UNCOR_STATUS[11:2]: begin
        rd_word = st.unc_sts & UNCOR_IMPL_MASK;
      end
      OFF_UNCOR_MASK[11:2]: begin
        rd_word = st.unc_mask;
      end
      default: begin
        if (hdr_off < 12'h010) begin
          rd_word = st.hdr_log[hdr_off[3:2]*32 +: 32];
        end else begin
          rd_word = 32'h0000_0000;
        end
      end
    endcase
    next_st.rvalid = I_CFG_RD;
    if (I_CFG_RD) begin
      next_st.rdata = rd_word;
    end

    // Resets: power reset clears all, warm reset keeps the error registers
    if (I_PWR_RST || I_RST) begin
      next_st.ctrl        = ROOT_CONTROL_RESET;
      next_st.pme_status  = 1'b0;
      next_st.pme_pending = 1'b0;
      next_st.pme_id      = 16'h0000;
      next_st.pme_pend_id = 16'h0000;
      next_st.tick_cnt    = 8'h00;
      next_st.ent_valid   = '0;
      next_st.ent_tag     = '0;
      next_st.ent_time    = '0;
      next_st.fc_inf      = 6'h00;
      next_st.next_seq    = 12'h000;
      next_st.acked_seq   = ACKED_SEQ_RESET;
      next_st.rdata       = 32'h0000_0000;
      next_st.rvalid      = 1'b0;
      next_st.serr        = 1'b0;
      next_st.pme_int     = 1'b0;
      next_st.unc_msg     = 1'b0;
      next_st.req_ready   = 1'b1;
    end
    if (I_PWR_RST) begin
      next_st.unc_sts  = UNCOR_STATUS_RESET;
      next_st.unc_mask = UNCOR_MASK_RESET;
      next_st.hdr_log  = '0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    st <= next_st;
  end

  assign O_CFG_RDATA    = st.rdata;
  assign O_CFG_RVALID   = st.rvalid;
  assign O_SYSTEM_ERROR = st.serr;
  assign O_PME_INT      = st.pme_int;
  assign O_REQ_READY    = st.req_ready;
  assign O_UNCOR_MSG    = st.unc_msg;
endmodule // prer_root_port_regs
`default_nettype wire

/* File: prer_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module prer_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_pme_go,
  input  wire logic [15:0] i_pme_id,
  input  wire logic        i_err_go,
  input  wire logic [1:0]  i_err_kind,
  input  wire logic        i_slow,
  output logic             o_pme_valid,
  output logic      [15:0] o_pme_id,
  output logic             o_err_valid,
  output logic      [1:0]  o_err_kind
);
  logic [3:0]  pme_sh = '0;
  logic [3:0]  err_sh = '0;
  logic [15:0] id_q   = '0;
  logic [1:0]  kind_q = '0;
  always_ff @(posedge i_clk) begin
    pme_sh <= {pme_sh[2:0] & {3{i_slow}}, i_pme_go};
    err_sh <= {err_sh[2:0] & {3{i_slow}}, i_err_go};
    if (i_pme_go) begin
      id_q <= i_pme_id;
    end
    if (i_err_go) begin
      kind_q <= i_err_kind;
    end
  end
  // Slow answers come four cycles after the request, three after fast ones; idle lines carry the inverse of the last value
  assign o_pme_valid = i_slow ? pme_sh[3] : pme_sh[0];
  assign o_pme_id    = o_pme_valid ? id_q : ~id_q;
  assign o_err_valid = i_slow ? err_sh[3] : err_sh[0];
  assign o_err_kind  = o_err_valid ? kind_q : ~kind_q;
endmodule // prer_far_model
`default_nettype wire

/* File: prer_root_port_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module prer_root_port_regs_sva (
  input wire logic        I_MCLK,
  input wire logic        I_RST,
  input wire logic        I_PWR_RST,
  input wire logic [11:0] I_CFG_ADDR,
  input wire logic        I_CFG_RD,
  input wire logic        I_CFG_WR,
  input wire logic [31:0] O_CFG_RDATA,
  input wire logic        O_CFG_RVALID,
  input wire logic        I_CMD_SERR_EN,
  input wire logic        I_ERR_MSG_VALID,
  input wire logic [1:0]  I_ERR_MSG_KIND,
  input wire logic        O_SYSTEM_ERROR,
  input wire logic        I_PME_MSG_VALID,
  input wire logic        O_PME_INT,
  input wire logic        I_REQ_ISSUE,
  input wire logic        O_REQ_READY
);
  import prer_pkg::*;
  logic was_rst;
  always_ff @(posedge I_MCLK) begin
    was_rst <= I_RST | I_PWR_RST;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST || I_PWR_RST);
  sequence s_rd(logic [11:0] a);
    I_CFG_RD && I_CFG_ADDR[11:2] == a[11:2];
  endsequence
  AST_RD_ANSWER: assert property (!was_rst |-> O_CFG_RVALID == $past(I_CFG_RD))
    else $error("read answer out of step");
  AST_RDATA_HOLD: assert property (!was_rst && !O_CFG_RVALID |-> $stable(O_CFG_RDATA))
    else $error("read data changed without a read");
  AST_POSTED: assert property (s_rd(OFF_POSTED_CREDITS) |=> O_CFG_RDATA == 32'h000C_0030)
    else $error("posted credits wrong");
  AST_NONPOSTED: assert property (s_rd(OFF_NONPOSTED_CREDITS) |=> O_CFG_RDATA == 32'h0008_0001)
    else $error("nonposted credits wrong");
  AST_CAP_HDR: assert property (s_rd(OFF_EXT_CAP_HEADER) |=> O_CFG_RDATA == 32'h0001_0001)
    else $error("capability header wrong");
  AST_UNC_RSVD: assert property (s_rd(OFF_UNCOR_STATUS) |=> (O_CFG_RDATA & 32'hFFE8_0FEF) == 0)
    else $error("unimplemented status bit set");
  AST_SERR_CAUSE: assert property (O_SYSTEM_ERROR |-> $past(I_ERR_MSG_VALID) && $past(I_ERR_MSG_KIND) != 2'h3)
    else $error("system error without a message");
  AST_SERR_CMD: assert property (O_SYSTEM_ERROR && $past(I_ERR_MSG_KIND) != MSG_COR |-> $past(I_CMD_SERR_EN))
    else $error("system error without command enable");
  AST_PME_RISE: assert property ($rose(O_PME_INT) |-> $past(I_PME_MSG_VALID) || $past(I_CFG_WR) || $past(I_PME_MSG_VALID, 2) || $past(I_CFG_WR, 2))
    else $error("pme interrupt without cause");
  AST_PME_FALL: assert property (!was_rst && $fell(O_PME_INT) |-> $past(I_CFG_WR) || $past(I_CFG_WR, 2))
    else $error("pme interrupt dropped without a write");
  AST_READY_FALL: assert property ($fell(O_REQ_READY) |-> $past(I_REQ_ISSUE))
    else $error("request table filled without an issue");
endmodule // prer_root_port_regs_sva
bind prer_root_port_regs prer_root_port_regs_sva prer_root_port_regs_sva_i (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_PWR_RST(I_PWR_RST), .I_CFG_ADDR(I_CFG_ADDR),
  .I_CFG_RD(I_CFG_RD), .I_CFG_WR(I_CFG_WR), .O_CFG_RDATA(O_CFG_RDATA),
  .O_CFG_RVALID(O_CFG_RVALID), .I_CMD_SERR_EN(I_CMD_SERR_EN), .I_ERR_MSG_VALID(I_ERR_MSG_VALID),
  .I_ERR_MSG_KIND(I_ERR_MSG_KIND), .O_SYSTEM_ERROR(O_SYSTEM_ERROR),
  .I_PME_MSG_VALID(I_PME_MSG_VALID), .O_PME_INT(O_PME_INT), .I_REQ_ISSUE(I_REQ_ISSUE),
  .O_REQ_READY(O_REQ_READY));
`default_nettype wire

/* File: prer_root_port_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module prer_root_port_regs_tb;
  import prer_pkg::*;
  logic         clk = 0, rst = 1, prst = 1, wr = 0, rd = 0, cmd_en = 0, issue = 0, cpl = 0;
  logic         fci = 0, fcu = 0, sent = 0, ack = 0, pgo = 0, ego = 0, slow = 0;
  logic         pv, ev_v, rvalid, serr, pint, ready, umsg;
  logic [1:0]   ekind = 0, ek, fct = 0;
  logic [2:0]   qf = 0;
  logic [4:0]   tag = 0, ctag = 0;
  logic [7:0]   fch = 0;
  logic [8:0]   ev = 0;
  logic [11:0]  addr = 0, fcd = 0, aseq = 0;
  logic [15:0]  pid = 0, pidw;
  logic [31:0]  wdata = 0, rdata;
  logic [127:0] hdr = 0;
  int           fails = 0, check_count = 0, cycles = 0;
  always #4 clk = ~clk;
  prer_root_port_regs #(.CPL_TIMEOUT_US(3)) prer_root_port_regs_i (
    .I_MCLK(clk), .I_RST(rst), .I_PWR_RST(prst), .I_CFG_ADDR(addr), .I_CFG_WR(wr),
    .I_CFG_RD(rd), .I_CFG_BE(4'hF), .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata),
    .O_CFG_RVALID(rvalid), .I_CMD_SERR_EN(cmd_en), .I_ERR_MSG_VALID(ev_v), .I_ERR_MSG_KIND(ek),
    .O_SYSTEM_ERROR(serr), .I_PME_MSG_VALID(pv), .I_PME_REQ_ID(pidw), .O_PME_INT(pint),
    .I_RX_HDR(hdr), .I_RX_UNSUPPORTED(ev[0]), .I_RX_LEN_ERR(ev[1]), .I_RX_BE_ERR(ev[2]),
    .I_RX_FIELD_ERR(ev[3]), .I_RX_POISONED(ev[4]), .I_RX_ABORT_REQ(ev[5]), .I_Q_PUSH(ev[8:6]),
    .I_Q_FULL(qf), .I_REQ_ISSUE(issue), .I_REQ_TAG(tag), .O_REQ_READY(ready),
    .I_CPL_VALID(cpl), .I_CPL_TAG(ctag), .I_FC_INIT_VALID(fci), .I_FC_UPD_VALID(fcu),
    .I_FC_TYPE(fct), .I_FC_HDR(fch), .I_FC_DATA(fcd), .I_TLP_SENT(sent), .I_ACK_VALID(ack),
    .I_ACK_SEQ(aseq), .O_UNCOR_MSG(umsg));
  prer_far_model prer_far_model_i (
    .i_clk(clk), .i_pme_go(pgo), .i_pme_id(pid), .i_err_go(ego), .i_err_kind(ekind),
    .i_slow(slow), .o_pme_valid(pv), .o_pme_id(pidw), .o_err_valid(ev_v), .o_err_kind(ek));
  task automatic end_sim();
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(n, e, rvalid === 1'b1 ? rdata : 'x);
  endtask
  task automatic pulse_rst(input bit pw);
    @(posedge clk);
    rst <= !pw;
    prst <= pw;
    repeat (2) @(posedge clk);
    rst <= 0;
    prst <= 0;
  endtask
  task automatic pme(input logic [15:0] id);
    @(posedge clk);
    pgo <= 1;
    pid <= id;
    @(posedge clk);
    pgo <= 0;
    cyc(1);
  endtask
  task automatic t_ro();
    wrt(OFF_POSTED_CREDITS, '1);
    wrt(OFF_EXT_CAP_HEADER, '1);
    rdc(OFF_POSTED_CREDITS, 32'h000C_0030, "posted");
    rdc(OFF_NONPOSTED_CREDITS, 32'h0008_0001, "nonposted");
    rdc(OFF_EXT_CAP_HEADER, 32'h0001_0001, "cap hdr");
    rdc(12'h0FC, 0, "unmapped");
    rdc(OFF_UNCOR_STATUS, 0, "unc reset");
    wrt(OFF_ROOT_PORT_CONTROL, '1);
    rdc(OFF_ROOT_PORT_CONTROL, 32'hF, "ctrl");
  endtask
  task automatic t_serr();
    logic e;
    for (int c = 0; c < 8; c++) begin
      wrt(OFF_ROOT_PORT_CONTROL, 32'(c));
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        cmd_en <= k[2];
        ego <= 1;
        ekind <= k[1:0];
        slow <= k[0];
        @(posedge clk);
        ego <= 0;
        cyc(k[0] ? 4 : 1);
        e = k[1:0] != 3 && c[k[1:0]] && (k[1:0] == 0 || k[2]);
        chk("serr", 32'(e), 32'(serr));
      end
    end
    slow <= 0;
  endtask
  task automatic t_pme();
    wrt(OFF_ROOT_PORT_CONTROL, 0);
    pme(16'h1234);
    rdc(OFF_ROOT_PORT_STATUS, 32'h0001_1234, "pme status");
    chk("pme int off", 0, 32'(pint));
    pme(16'h5678);
    wrt(OFF_ROOT_PORT_STATUS, 32'h0000_FFFF);
    rdc(OFF_ROOT_PORT_STATUS, 32'h0003_1234, "pme pending");
    wrt(OFF_ROOT_PORT_CONTROL, 32'h8);
    cyc(1);
    chk("pme int on", 1, 32'(pint));
    wrt(OFF_ROOT_PORT_STATUS, 32'h0001_0000);
    rdc(OFF_ROOT_PORT_STATUS, 32'h0001_5678, "pme next");
    chk("pme int held", 1, 32'(pint));
    wrt(OFF_ROOT_PORT_STATUS, 32'h0001_0000);
    cyc(2);
    chk("pme int drop", 0, 32'(pint));
    pme(16'h0ABC);
    cyc(1);
    chk("pme int new", 1, 32'(pint));
  endtask
  task automatic t_unc();
    logic [31:0] b;
    for (int i = 0; i < 9; i++) begin
      b = i == 0 ? 32'h10_0000 : i < 4 ? 32'h4_0000 : i == 4 ? 32'h1000 : i == 5 ? 32'h8000 : 32'h2_0000;
      @(posedge clk);
      ev <= 9'(1 << i);
      qf <= 3'h7;
      hdr <= {4{32'(i) + 32'hA0}};
      @(posedge clk);
      ev <= 0;
      #1;
      chk("unc msg", 1, 32'(umsg));
      rdc(OFF_UNCOR_STATUS, b, "unc bit");
      rdc(OFF_HEADER_LOG0, 32'(i) + 32'hA0, "hdr log");
      wrt(OFF_UNCOR_STATUS, b);
      rdc(OFF_UNCOR_STATUS, 0, "unc clear");
    end
    @(posedge clk);
    ev <= 9'h040;
    qf <= 0;
    hdr <= '1;
    @(posedge clk);
    ev <= 9'h010;
    @(posedge clk);
    ev <= 9'h001;
    hdr <= 0;
    @(posedge clk);
    ev <= 0;
    rdc(OFF_UNCOR_STATUS, 32'h0010_1000, "no overflow");
    rdc(OFF_HEADER_LOG0, '1, "hdr first only");
    rdc(OFF_HEADER_LOG0 + 12'h00C, '1, "hdr dw3");
    wrt(OFF_UNCOR_MASK, 32'h1000);
    pulse_rst(0);
    rdc(OFF_UNCOR_STATUS, 32'h0010_1000, "sticky");
    wrt(OFF_UNCOR_STATUS, '1);
    @(posedge clk);
    ev <= 9'h010;
    @(posedge clk);
    ev <= 0;
    #1;
    chk("masked msg", 0, 32'(umsg));
    rdc(OFF_UNCOR_STATUS, 32'h1000, "masked log");
    pulse_rst(1);
    rdc(OFF_UNCOR_STATUS, 0, "power reset");
  endtask
  task automatic t_cpl();
    @(posedge clk);
    issue <= 1;
    tag <= 3;
    @(posedge clk);
    issue <= 0;
    cpl <= 1;
    ctag <= 3;
    @(posedge clk);
    ctag <= 7;
    @(posedge clk);
    cpl <= 0;
    rdc(OFF_UNCOR_STATUS, 32'h1_0000, "unexp cpl");
    wrt(OFF_UNCOR_STATUS, '1);
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      issue <= 1;
      tag <= 5'(t);
    end
    @(posedge clk);
    issue <= 0;
    cyc(1);
    chk("table full", 0, 32'(ready));
    cyc(200);
    rdc(OFF_UNCOR_STATUS, 0, "no early timeout");
    cyc(200);
    rdc(OFF_UNCOR_STATUS, 32'h4000, "timeout");
    chk("freed", 1, 32'(ready));
    wrt(OFF_UNCOR_STATUS, '1);
  endtask
  task automatic t_link();
    for (int t = 0; t < 3; t++) begin
      @(posedge clk);
      fci <= 1;
      fct <= 2'(t);
      fch <= 0;
      fcd <= 0;
      @(posedge clk);
      fci <= 0;
      fcu <= 1;
      @(posedge clk);
      fcu <= 0;
      rdc(OFF_UNCOR_STATUS, 0, "fc infinite");
      @(posedge clk);
      fcu <= 1;
      fch <= 8'(t == 2);
      fcd <= t == 2 ? 12'h000 : 12'h010;
      @(posedge clk);
      fcu <= 0;
      rdc(OFF_UNCOR_STATUS, 32'h2000, "fc error");
      wrt(OFF_UNCOR_STATUS, '1);
    end
    repeat (3) begin
      @(posedge clk);
      sent <= 1;
    end
    @(posedge clk);
    sent <= 0;
    ack <= 1;
    aseq <= 1;
    repeat (2) @(posedge clk);
    aseq <= 2;
    @(posedge clk);
    ack <= 0;
    rdc(OFF_UNCOR_STATUS, 0, "ack ok");
    @(posedge clk);
    ack <= 1;
    aseq <= 5;
    @(posedge clk);
    ack <= 0;
    rdc(OFF_UNCOR_STATUS, 32'h10, "ack bad");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    prst <= 0;
    t_ro();
    t_serr();
    t_pme();
    t_unc();
    t_cpl();
    t_link();
    end_sim();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
endmodule // prer_root_port_regs_tb
`default_nettype wire
